// *** arb_timer_consts.svh ***
// Purpose: constants of the serial bus arbiter timer
// Assumes: included by its bare name
// Notes:   offsets are register indices on the plain port
`ifndef ARB_TIMER_CONSTS_SVH
`define ARB_TIMER_CONSTS_SVH
`define ADDR_CTRL      1'h0
`define ADDR_COUNT     1'h1
`define CTRL_MODE_HI   7
`define CTRL_MODE_LO   6
`define CTRL_LOST      5
`define CTRL_CLK_SEL   4
`define CTRL_DONE      3
`define CTRL_RUNNING   2
`define CTRL_OVERFLOW  1
`define CTRL_MSB       0
`define RST_BYTE       8'h00
`define RST_COUNT      9'h000
`define COUNT_MAX      9'h1ff
`define SAMPLE_BUS     9'h038
`define SAMPLE_PRESC   9'h008
`define BUS_DIV        4
`endif

// *** arb_timer_pkg.sv ***
// Purpose: types of the serial bus arbiter timer
// Assumes: nothing
// Notes:   register request travels as one packed struct
package arb_timer_pkg;
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic       addr;
    logic [7:0] wdata;
  } reg_req_t;
  typedef enum logic [1:0] {
    MODE_IDLE    = 2'b00,
    MODE_MEASURE = 2'b01,
    MODE_ARB     = 2'b10,
    MODE_RSVD    = 2'b11
  } mode_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_RUN  = 2'b10,
    ST_DONE = 2'b11
  } state_t;
endpackage

// *** serial_bus_arbiter_timer.sv ***
// Purpose: 9-bit arbiter counter for bit time, break length and bus arbitration
// Assumes: prescaler ticks and internal tx are on mclk_in; rx pin is asynchronous
// Notes:   one register per index on the plain port, read data one cycle later
//
// Design decisions made here: the placing of the registers and the strobed register port.
`timescale 1ns/100ps
`include "arb_timer_consts.svh"
module serial_bus_arbiter_timer #(
  parameter int BUS_DIV = `BUS_DIV
) (
  input  wire                      mclk_in,
  input  wire                      sys_rst_in,
  input  wire arb_timer_pkg::reg_req_t bus_req_in,
  output logic [7:0]               rdata_out,
  input  wire                      rxd_in,
  input  wire                      internal_serial_tx_in,
  input  wire                      bus_presc_tick_in,
  input  wire                      osc_presc_tick_in,
  input  wire                      prescaler_source_select_in,
  output logic                     tx_pin_out
);
  import arb_timer_pkg::*;

  localparam int DIV_W = $clog2(BUS_DIV);

  mode_t        mode_ff;
  logic         clk_sel_ff;
  logic         lost_ff;
  logic         done_ff;
  logic         ovf_ff;
  logic [8:0]   cnt_ff;
  logic [8:0]   nxt_cnt;
  state_t       state_ff;
  state_t       nxt_state;
  logic [DIV_W-1:0] div_ff;
  logic         half_ff;
  logic         rx_meta_ff;
  logic         rx_ff;
  logic         rx_prev_ff;
  logic         tx_prev_ff;
  logic         seen_low_ff;
  logic         sampled_ff;
  logic         ctrl_wr;
  logic         div_tick;
  logic         presc_tick;
  logic         tick;
  logic         rx_fall;
  logic         rx_rise;
  logic         tx_rise;
  logic         tx_fall;
  logic         measuring;
  logic         arbitrating;
  logic         running;
  logic         sample_hit;
  logic         abort;
  logic         finish;
  logic [8:0]   sample_at;
  logic [7:0]   ctrl_byte;

  // decode of one register index, used by write and read paths
  function automatic logic hit(input reg_req_t req, input logic idx);
    hit = (req.addr == idx);
  endfunction

  assign ctrl_wr = bus_req_in.wr && hit(bus_req_in, `ADDR_CTRL);

  // pin synchroniser; only rx_ff and later are looked at
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      rx_meta_ff <= 1'b1;
      rx_ff      <= 1'b1;
      rx_prev_ff <= 1'b1;
    end else begin
      rx_meta_ff <= rxd_in;
      rx_ff      <= rx_meta_ff;
      rx_prev_ff <= rx_ff;
    end
  end

  // internal tx is same-clock logic, no synchroniser needed
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      tx_prev_ff <= 1'b1;
    end else begin
      tx_prev_ff <= internal_serial_tx_in;
    end
  end

  assign rx_fall = rx_prev_ff && !rx_ff;
  assign rx_rise = !rx_prev_ff && rx_ff;
  assign tx_rise = !tx_prev_ff && internal_serial_tx_in;
  assign tx_fall = tx_prev_ff && !internal_serial_tx_in;

  // bus clock divider, ratio set by parameter
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      div_ff <= '0;
    end else if (div_tick) begin
      div_ff <= '0;
    end else begin
      div_ff <= div_ff + 1'b1;
    end
  end
  assign div_tick = (div_ff == DIV_W'(BUS_DIV - 1));

  // prescaler source follows the config select bit
  assign presc_tick = prescaler_source_select_in ? osc_presc_tick_in : bus_presc_tick_in;

  // half rate of the prescaler output
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      half_ff <= 1'b0;
    end else if (presc_tick) begin
      half_ff <= !half_ff;
    end
  end

  // counter tick source by clock select
  assign tick = clk_sel_ff ? (presc_tick && half_ff) : div_tick;

  // mode decode; the reserved code falls through to idle
  assign measuring   = (mode_ff == MODE_MEASURE);
  assign arbitrating = (mode_ff == MODE_ARB);
  assign running     = (state_ff == ST_RUN);

  // sample point depends on clock select
  assign sample_at  = clk_sel_ff ? `SAMPLE_PRESC : `SAMPLE_BUS;
  assign sample_hit = arbitrating && running && (cnt_ff == sample_at) && !sampled_ff;
  // tx fall before rx is seen low at the sample point aborts the attempt
  assign abort      = arbitrating && running && tx_fall && !seen_low_ff && !tx_rise;
  assign finish     = measuring && running &&
                      (clk_sel_ff ? rx_rise : rx_fall);

  // mode and select registers, cleared by reset
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      mode_ff    <= MODE_IDLE;
      clk_sel_ff <= 1'b0;
    end else if (ctrl_wr) begin
      mode_ff    <= mode_t'({bus_req_in.wdata[`CTRL_MODE_HI], bus_req_in.wdata[`CTRL_MODE_LO]});
      clk_sel_ff <= bus_req_in.wdata[`CTRL_CLK_SEL];
    end
  end

  // sequencer; a control write restarts the wait for a start event
  always_comb begin
    nxt_state = state_ff;
    if (!measuring && !arbitrating) begin
      nxt_state = ST_IDLE;
    end else if (ctrl_wr) begin
      nxt_state = ST_WAIT;
    end else begin
      unique case (state_ff)
        // a start event in the first cycle after a mode write is not lost
        ST_IDLE, ST_WAIT: begin
          nxt_state = ST_WAIT;
          if (measuring && !clk_sel_ff && rx_fall) begin
            nxt_state = ST_RUN;
          end
          if (measuring && clk_sel_ff && !rx_ff) begin
            nxt_state = ST_RUN;
          end
          if (arbitrating && tx_rise) begin
            nxt_state = ST_RUN;
          end
        end
        ST_RUN: begin
          if (finish) begin
            nxt_state = ST_DONE;
          end else if (abort) begin
            nxt_state = ST_WAIT;
          end
        end
        ST_DONE: begin
          if (arbitrating && tx_rise) begin
            nxt_state = ST_RUN;
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // counter; write wins over counting
  always_comb begin
    nxt_cnt = cnt_ff;
    // cleared by write or idle mode
    if (ctrl_wr || (!measuring && !arbitrating)) begin
      nxt_cnt = `RST_COUNT;
    // restart on tx rise, reset on abort
    end else if (arbitrating && (tx_rise || abort)) begin
      nxt_cnt = `RST_COUNT;
    end else if (running && tick && !finish) begin
      nxt_cnt = cnt_ff + 9'h001;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      cnt_ff <= `RST_COUNT;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  // arbitration bookkeeping per transmitted bit
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in || !arbitrating || tx_rise) begin
      seen_low_ff <= 1'b0;
      sampled_ff  <= 1'b0;
    end else begin
      // own echo lags through the synchroniser; only the sample point senses rx
      if (sample_hit && !rx_ff) begin
        seen_low_ff <= 1'b1;
      end
      if (sample_hit) begin
        sampled_ff <= 1'b1;
      end
    end
  end

  // lost flag; a set in the clearing cycle wins
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      lost_ff <= 1'b0;
    end else if (sample_hit && !rx_ff) begin
      lost_ff <= 1'b1;
    end else if (ctrl_wr && !bus_req_in.wdata[`CTRL_MODE_HI]) begin
      lost_ff <= 1'b0;
    end
  end

  // done flag, set wins over write clear
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      done_ff <= 1'b0;
    end else if (finish) begin
      done_ff <= 1'b1;
    end else if (ctrl_wr) begin
      done_ff <= 1'b0;
    end
  end

  // overflow on carry out of nine bits
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      ovf_ff <= 1'b0;
    end else if (running && tick && !finish && (cnt_ff == `COUNT_MAX)) begin
      ovf_ff <= 1'b1;
    end else if (ctrl_wr) begin
      ovf_ff <= 1'b0;
    end
  end

  // status view of the control register
  always_comb begin
    ctrl_byte                 = `RST_BYTE;
    ctrl_byte[`CTRL_MODE_HI]  = mode_ff[1];
    ctrl_byte[`CTRL_MODE_LO]  = mode_ff[0];
    ctrl_byte[`CTRL_LOST]     = lost_ff;
    ctrl_byte[`CTRL_CLK_SEL]  = clk_sel_ff;
    ctrl_byte[`CTRL_DONE]     = done_ff;
    ctrl_byte[`CTRL_RUNNING]  = running;
    ctrl_byte[`CTRL_OVERFLOW] = ovf_ff;
    ctrl_byte[`CTRL_MSB]      = cnt_ff[8];
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in || !bus_req_in.rd) begin
      rdata_out <= `RST_BYTE;
    end else if (hit(bus_req_in, `ADDR_CTRL)) begin
      rdata_out <= ctrl_byte;
    end else begin
      rdata_out <= cnt_ff[7:0];
    end
  end

  // tx pin held high while lost; costs one cycle of latency
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      tx_pin_out <= 1'b1;
    end else begin
      tx_pin_out <= lost_ff || internal_serial_tx_in;
    end
  end

  sequence s_div_gap;
    !div_tick [*3] ##1 div_tick;
  endsequence

  sequence s_tx_start;
    arbitrating && tx_rise && !ctrl_wr;
  endsequence

  property p_idle_hold;
    @(posedge mclk_in) disable iff (sys_rst_in)
      (!measuring && !arbitrating) |=> (cnt_ff == `RST_COUNT) && !running;
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("idle did not hold counter");

  property p_wr_clear;
    @(posedge mclk_in) disable iff (sys_rst_in)
      ctrl_wr && !running |=> (cnt_ff == `RST_COUNT) && !done_ff && !ovf_ff;
  endproperty
  a_wr_clear: assert property (p_wr_clear) else $error("control write did not clear");

  property p_lost_clear;
    @(posedge mclk_in) disable iff (sys_rst_in)
      ctrl_wr && !bus_req_in.wdata[`CTRL_MODE_HI] && !arbitrating |=> !lost_ff;
  endproperty
  a_lost_clear: assert property (p_lost_clear) else $error("lost flag not cleared");

  property p_lost_set;
    @(posedge mclk_in) disable iff (sys_rst_in)
      sample_hit && !rx_ff |=> lost_ff ##1 tx_pin_out;
  endproperty
  a_lost_set: assert property (p_lost_set) else $error("lost not set or tx not forced");

  property p_tx_force;
    @(posedge mclk_in) disable iff (sys_rst_in)
      lost_ff |=> tx_pin_out;
  endproperty
  a_tx_force: assert property (p_tx_force) else $error("tx pin not forced high");

  property p_arb_start;
    @(posedge mclk_in) disable iff (sys_rst_in)
      s_tx_start |=> running && (cnt_ff == `RST_COUNT);
  endproperty
  a_arb_start: assert property (p_arb_start) else $error("tx rise did not start counter");

  property p_abort;
    @(posedge mclk_in) disable iff (sys_rst_in)
      abort && !ctrl_wr |=> (state_ff == ST_WAIT) && (cnt_ff == `RST_COUNT);
  endproperty
  a_abort: assert property (p_abort) else $error("abort did not reset counter");

  property p_edge_finish;
    @(posedge mclk_in) disable iff (sys_rst_in)
      finish && !ctrl_wr |=> done_ff && !running && $stable(cnt_ff);
  endproperty
  a_edge_finish: assert property (p_edge_finish) else $error("measurement did not finish");

  property p_break_start;
    @(posedge mclk_in) disable iff (sys_rst_in)
      measuring && clk_sel_ff && (state_ff == ST_WAIT) && !rx_ff && !ctrl_wr |=> running;
  endproperty
  a_break_start: assert property (p_break_start) else $error("break count did not start");

  property p_overflow;
    @(posedge mclk_in) disable iff (sys_rst_in)
      running && tick && !finish && !ctrl_wr && !tx_rise && !abort &&
      (cnt_ff == `COUNT_MAX) |=> ovf_ff && (cnt_ff == `RST_COUNT);
  endproperty
  a_overflow: assert property (p_overflow) else $error("overflow not flagged");

  property p_bus_rate;
    @(posedge mclk_in) disable iff (sys_rst_in)
      div_tick |=> s_div_gap;
  endproperty
  a_bus_rate: assert property (p_bus_rate) else $error("bus divider rate wrong");

endmodule

// *** serial_bus_arbiter_timer_bench.sv ***
// Purpose: self-checking bench of the serial bus arbiter timer
// Assumes: default bus divider of 4, prescaler ticks made here
// Notes:   measured counts are checked with a small tolerance for tick phase
`timescale 1ns/100ps
module serial_bus_arbiter_timer_bench;
  import arb_timer_pkg::*;
  typedef struct {string name; logic [7:0] exp; logic [7:0] mask; int tol;} note_t;
  logic       mclk_in, sys_rst_in, rxd, itx, bus_tick, osc_tick, src_sel, tx_pin, dom, rd_q;
  logic [1:0] lag;
  logic [7:0] rdata;
  reg_req_t   bus_req;
  note_t      notes[$];
  int         err_total, n_checks, seed, len, tick_cnt;

  serial_bus_arbiter_timer i_dut (
    .mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .bus_req_in(bus_req), .rdata_out(rdata),
    .rxd_in(rxd), .internal_serial_tx_in(itx), .bus_presc_tick_in(bus_tick),
    .osc_presc_tick_in(osc_tick), .prescaler_source_select_in(src_sel), .tx_pin_out(tx_pin)
  );
  serial_bus_node_model i_node (
    .mclk_in(mclk_in), .tx_pin_in(tx_pin), .dominant_in(dom), .lag_in(lag), .rxd_out(rxd)
  );

  initial begin
    mclk_in = 1'b0;
    forever #10 mclk_in = ~mclk_in;
  end

  // bus ticks every 2 clocks, oscillator ticks every 3
  always @(posedge mclk_in) begin
    tick_cnt <= tick_cnt + 1;
    bus_tick <= (tick_cnt % 2 == 0);
    osc_tick <= (tick_cnt % 3 == 0);
    rd_q     <= bus_req.rd;
  end

  task automatic finish_test();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge mclk_in);
  endtask

  task automatic wr(input logic a, input logic [7:0] d);
    @(posedge mclk_in);
    bus_req <= '{1'b1, 1'b0, a, d};
    @(posedge mclk_in);
    bus_req <= '0;
  endtask

  task automatic rd(input string nm, input logic a, input logic [7:0] e, m, input int tol);
    notes.push_back('{nm, e, m, tol});
    @(posedge mclk_in);
    bus_req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge mclk_in);
    bus_req <= '0;
  endtask

  task automatic chk(input string nm, input logic e, g);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  // read data stand in the cycle after the strobe, sampled mid-cycle
  always @(negedge mclk_in) begin
    if (rd_q === 1'b1 && notes.size() > 0) begin
      note_t n;
      n = notes.pop_front();
      n_checks++;
      if (((rdata & n.mask) inside {[int'(n.exp) - n.tol : int'(n.exp) + n.tol]}) !== 1'b1)
      begin
        err_total++;
        $display("Error %s expected %h seen %h", n.name, n.exp, rdata & n.mask);
      end
    end
  end

  initial begin
    repeat (50000) @(posedge mclk_in);
    err_total++;
    $display("Error watchdog expected end seen hang");
    finish_test();
  end

  initial begin
    seed = 32'h2559;
    {sys_rst_in, itx, src_sel, dom} = 4'b1100;
    lag = 2'h0;
    bus_req = '0;
    err_total = 0;
    n_checks = 0;
    idle(2);
    sys_rst_in <= 1'b0;
    rd("ctrl reset", 1'b0, 8'h00, 8'hff, 0);
    rd("count reset", 1'b1, 8'h00, 8'hff, 0);
    // mode 11 is never written by this bench
    wr(1'b0, 8'h3f);
    wr(1'b1, 8'h5a);
    rd("ctrl ro bits", 1'b0, 8'h10, 8'hff, 0);
    rd("count idle", 1'b1, 8'h00, 8'hff, 0);
    wr(1'b0, 8'h40);
    idle(20);
    dom <= 1'b1;
    idle(10);
    dom <= 1'b0;
    idle(790);
    rd("ctrl running", 1'b0, 8'h44, 8'hff, 0);
    idle(798);
    dom <= 1'b1;
    idle(10);
    rd("ctrl done", 1'b0, 8'h49, 8'hff, 0);
    rd("count bit time", 1'b1, 8'h90, 8'hff, 1);
    dom <= 1'b0;
    wr(1'b0, 8'h40);
    rd("ctrl cleared", 1'b0, 8'h40, 8'hff, 0);
    rd("count cleared", 1'b1, 8'h00, 8'hff, 0);
    len = 240 + ($random(seed) & 63);
    lag <= 2'h3;
    dom <= 1'b1;
    src_sel <= 1'b1;
    idle(10);
    wr(1'b0, 8'h50);
    idle(len);
    dom <= 1'b0;
    idle(10);
    rd("ctrl break", 1'b0, 8'h58, 8'hff, 0);
    rd("count break", 1'b1, 8'((len + 2) / 6), 8'hff, 2);
    lag <= 2'h0;
    wr(1'b0, 8'h80);
    itx <= 1'b0;
    idle(10);
    chk("tx pin follows", 1'b0, tx_pin);
    itx <= 1'b1;
    idle(2200);
    rd("ctrl won", 1'b0, 8'h86, 8'hff, 0);
    rd("count wrapped", 1'b1, 8'h26, 8'hff, 2);
    itx <= 1'b0;
    idle(5);
    rd("ctrl restart", 1'b0, 8'h82, 8'hff, 0);
    rd("count restart", 1'b1, 8'h00, 8'hff, 0);
    itx <= 1'b1;
    idle(100);
    dom <= 1'b1;
    idle(300);
    rd("ctrl lost", 1'b0, 8'ha2, 8'hfb, 0);
    itx <= 1'b0;
    idle(3);
    chk("tx pin forced", 1'b1, tx_pin);
    dom <= 1'b0;
    wr(1'b0, 8'h00);
    idle(2);
    chk("tx pin released", 1'b0, tx_pin);
    rd("ctrl lost cleared", 1'b0, 8'h00, 8'hff, 0);
    wr(1'b0, 8'h90);
    itx <= 1'b1;
    idle(20);
    dom <= 1'b1;
    idle(100);
    rd("ctrl lost presc", 1'b0, 8'hb0, 8'hfb, 0);
    dom <= 1'b0;
    wr(1'b0, 8'h90);
    rd("ctrl lost kept", 1'b0, 8'hb0, 8'hff, 0);
    for (int i = 0; i < 10 && notes.size() > 0; i++) idle(1);
    if (notes.size() > 0) begin
      err_total++;
      $display("Error drain expected 0 seen %0d", notes.size());
    end
    finish_test();
  end
endmodule

// *** serial_bus_node_model.sv ***
// Purpose: other nodes on the single-wire serial bus
// Assumes: open-drain wire with pull-up, low is dominant
// Notes:   dominant request takes effect lag_in + 1 cycles late
`timescale 1ns/100ps
module serial_bus_node_model (
  input  wire       mclk_in,
  input  wire       tx_pin_in,
  input  wire       dominant_in,
  input  wire [1:0] lag_in,
  output logic      rxd_out
);
  logic [3:0] dom_ff;

  always_ff @(posedge mclk_in) begin
    dom_ff <= {dom_ff[2:0], dominant_in};
  end

  // dominant low wins
  // slow nodes modelled by the lag, never by a wrong level
  assign rxd_out = tx_pin_in & ~dom_ff[lag_in];
endmodule
